// ### rtl/slo_defs.vh
// slo_defs.vh: register offsets, control fields, reset values and frame constants
// assumes: included by the transmit line/path overhead design files
`ifndef SLO_DEFS_VH
`define SLO_DEFS_VH
// register offsets (byte-wide registers on a plain 8-bit address port)
`define SLO_ADDR_LINE_CTRL 8'h0D
`define SLO_ADDR_PATH_CTRL 8'h0E
`define SLO_ADDR_K2 8'h11
`define SLO_ADDR_SEC_TRACE 8'h68
`define SLO_ADDR_PATH_TRACE 8'h69
`define SLO_ADDR_STATUS 8'h70
// line control fields
`define SLO_LN_SDH_PTR 7
`define SLO_LN_PTR_DIS 6
`define SLO_LN_B2_DIS 5
`define SLO_LN_DL_EN 4
`define SLO_LN_AIS 3
`define SLO_LN_RDI 2
`define SLO_LN_RDI_AUTO 1
`define SLO_LN_FEBE_AUTO 0
// path control fields
`define SLO_PT_TRACE_EN 7
`define SLO_PT_B3_DIS 6
`define SLO_PT_FEBE_AUTO 5
`define SLO_PT_AIS 4
`define SLO_PT_RDI_AUTO 0
// reset values
`define SLO_LINE_CTRL_RST 8'h03
`define SLO_PATH_CTRL_RST 8'h23
`define SLO_K2_RST 8'h00
// pointer and overhead byte values
`define SLO_H1_SONET 8'h62
`define SLO_H1_SDH 8'h6A
`define SLO_H2_VAL 8'h0A
`define SLO_PTR_FORCED 8'h33
`define SLO_ZERO_BYTE 8'h00
`define SLO_ONES_BYTE 8'hFF
`define SLO_LRDI_CODE 3'h6
// trace length and path rdi hold time in frames
`define SLO_TRACE_LEN 64
`define SLO_PRDI_HOLD_FRAMES 4'hA
`endif

// ### rtl/slo_trace_buf.v
// slo_trace_buf.v: 64-byte cyclic trace store with auto-advancing write and send pointers
// assumes: single clock, writes and frame steps are one-cycle strobes
`timescale 1ns/1ps
`include "slo_defs.vh"
module slo_trace_buf (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // software side
  input wire wr_i,
  input wire [7:0] wdata_i,
  output wire [5:0] wptr_o,
  // transmit side
  input wire step_i,
  output reg [7:0] byte_o
);
  reg [7:0] mem [0:`SLO_TRACE_LEN-1];
  reg [5:0] wptr_q;
  reg [5:0] sptr_q;
  assign wptr_o = wptr_q;
  // storage has no reset; contents are undefined until software loads them
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[wptr_q] <= wdata_i;
    end
  end
  // pointers wrap naturally at 64 because they are six bits wide
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_q <= 6'h00;
      sptr_q <= 6'h00;
      byte_o <= 8'h00;
    end else begin
      if (wr_i) begin
        wptr_q <= wptr_q + 6'h01; // R20
      end
      if (step_i) begin
        byte_o <= mem[sptr_q];
        sptr_q <= sptr_q + 6'h01;
      end
    end
  end
endmodule // slo_trace_buf

// ### rtl/slo_tx_overhead.v
// slo_tx_overhead.v: transmit line and path overhead control for an STS-3c framer
// assumes: frame_start_i marks each frame, receive alarms and bip counts arrive synchronous
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "slo_defs.vh"
//
// Contract
// R1 - send 64-byte software section trace in J0, cycling each frame
// R2 - send 64-byte software path trace in J1, cycling each frame
// R3 - sdh select gives H1/H2 6A/0A, else 62/0A
// R4 - pointer disable forces H1 and H2 to 33, overriding select
// R5 - line parity disable sends B2 as 00, else computed line bip
// R6 - data link enable passes D4-D12, else forces them to 00
// R7 - line ais sets every non-section-overhead bit to one
// R8 - line rdi insert sets K2 bits 6-8 to 110, else register
// R9 - auto line rdi on LOS, LOF or AIS-L when enabled
// R10 - auto line febe from receiver line bip errors when enabled
// R11 - path trace enable sends trace in J1, else 00
// R12 - path parity disable sends B3 as 00, else computed path bip
// R13 - auto path febe from received path bip errors when enabled
// R14 - path ais insert replaces path content while bit set
// R15 - without auto path rdi, control bits 3:1 go to G1 bits 5-7
// R16 - auto path rdi held at least 10 frames after path defects
// R17 - software K2 register supplies K2, first STS-1 only
// R18 - path ais forces path bytes and H1/H2/H3 to all ones
// R19 - febe carries last frame bip error count into next frame
// R20 - trace written through one offset, auto pointer wrapping at 64
module slo_tx_overhead (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // frame timing and receive defects
  input wire frame_start_i,
  input wire rx_los_i,
  input wire rx_lof_i,
  input wire rx_ais_l_i,
  input wire rx_lop_i,
  input wire rx_ais_p_i,
  input wire rx_uneq_p_i,
  input wire rx_plm_p_i,
  input wire [7:0] rx_b2_err_i,
  input wire [3:0] rx_b3_err_i,
  // byte position in the outgoing frame
  input wire [3:0] byte_sel_i,
  input wire [1:0] sts_sel_i,
  input wire sec_oh_i,
  input wire path_area_i,
  // data sources from the framer
  input wire [7:0] data_i,
  input wire [7:0] b2_calc_i,
  input wire [7:0] b3_calc_i,
  input wire [7:0] dl_byte_i,
  input wire [7:0] k1_i,
  // resulting byte and per-frame overhead values
  output reg [7:0] data_o,
  output reg [7:0] j0_o,
  output reg [7:0] j1_o,
  output reg [7:0] k2_o,
  output reg [7:0] g1_o,
  output reg [7:0] m1_o,
  output wire line_rdi_o,
  output wire path_rdi_o
);
  // byte selector codes for the output mux
  localparam SEL_PAYLOAD = 4'h0;
  localparam SEL_H1 = 4'h1;
  localparam SEL_H2 = 4'h2;
  localparam SEL_H3 = 4'h3;
  localparam SEL_B2 = 4'h4;
  localparam SEL_DL = 4'h5;
  localparam SEL_K1 = 4'h6;
  localparam SEL_K2 = 4'h7;
  localparam SEL_J1 = 4'h8;
  localparam SEL_B3 = 4'h9;
  localparam SEL_G1 = 4'hA;
  localparam SEL_M1 = 4'hB;
  localparam SEL_J0 = 4'hC;
  // path rdi hold states
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  reg [7:0] line_ctrl_q;
  reg [7:0] path_ctrl_q;
  reg [7:0] k2_q;
  reg [3:0] hold_cnt_q;
  reg [3:0] hold_cnt_d;
  reg prdi_st_q;
  reg prdi_st_d;
  reg [7:0] line_febe_q;
  reg [3:0] path_febe_q;
  reg [7:0] ov_byte;
  wire sec_wr;
  wire path_wr;
  wire [5:0] sec_wptr;
  wire [5:0] path_wptr;
  wire [7:0] sec_byte;
  wire [7:0] path_byte;
  wire line_defect;
  wire path_defect;

  // register write decode
  function is_addr;
    input [7:0] a;
    input [7:0] cmp;
    begin
      is_addr = (a == cmp);
    end
  endfunction

  assign sec_wr = wr_i & is_addr(addr_i, `SLO_ADDR_SEC_TRACE);
  assign path_wr = wr_i & is_addr(addr_i, `SLO_ADDR_PATH_TRACE);

  // control registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_ctrl_q <= `SLO_LINE_CTRL_RST;
      path_ctrl_q <= `SLO_PATH_CTRL_RST;
      k2_q <= `SLO_K2_RST;
    end else if (wr_i) begin
      if (is_addr(addr_i, `SLO_ADDR_LINE_CTRL)) begin
        line_ctrl_q <= wdata_i;
      end
      if (is_addr(addr_i, `SLO_ADDR_PATH_CTRL)) begin
        path_ctrl_q <= wdata_i;
      end
      if (is_addr(addr_i, `SLO_ADDR_K2)) begin
        k2_q <= wdata_i; // R17
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SLO_ADDR_LINE_CTRL: begin
          rdata_o <= line_ctrl_q;
        end
        `SLO_ADDR_PATH_CTRL: begin
          rdata_o <= path_ctrl_q;
        end
        `SLO_ADDR_K2: begin
          rdata_o <= k2_q;
        end
        `SLO_ADDR_SEC_TRACE: begin
          rdata_o <= {2'b00, sec_wptr}; // write pointer, the buffer itself is write only
        end
        `SLO_ADDR_PATH_TRACE: begin
          rdata_o <= {2'b00, path_wptr};
        end
        `SLO_ADDR_STATUS: begin
          rdata_o <= {2'b00, prdi_st_q, line_rdi_o, hold_cnt_q};
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // trace stores advance one byte per frame
  slo_trace_buf u_sec_trace (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(sec_wr),
    .wdata_i(wdata_i),
    .wptr_o(sec_wptr),
    .step_i(frame_start_i), // R1
    .byte_o(sec_byte)
  );

  slo_trace_buf u_path_trace (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(path_wr),
    .wdata_i(wdata_i),
    .wptr_o(path_wptr),
    .step_i(frame_start_i), // R2
    .byte_o(path_byte)
  );

  // defect groups feeding automatic rdi
  assign line_defect = rx_los_i | rx_lof_i | rx_ais_l_i;
  assign path_defect = line_defect | rx_lop_i | rx_ais_p_i | rx_uneq_p_i | rx_plm_p_i;

  // line rdi: forced by software or raised by receive defects when automatic
  assign line_rdi_o = line_ctrl_q[`SLO_LN_RDI] |
    (line_ctrl_q[`SLO_LN_RDI_AUTO] & line_defect); // R9

  // path rdi hold: reload while defect stands, then count frames down
  always @* begin
    prdi_st_d = prdi_st_q;
    hold_cnt_d = hold_cnt_q;
    case (prdi_st_q)
      ST_IDLE: begin
        if (path_defect) begin
          prdi_st_d = ST_HOLD;
          hold_cnt_d = `SLO_PRDI_HOLD_FRAMES;
        end
      end
      ST_HOLD: begin
        if (path_defect) begin
          hold_cnt_d = `SLO_PRDI_HOLD_FRAMES; // R16
        end else if (frame_start_i) begin
          if (hold_cnt_q == 4'h1) begin
            prdi_st_d = ST_IDLE;
            hold_cnt_d = 4'h0;
          end else begin
            hold_cnt_d = hold_cnt_q - 4'h1;
          end
        end
      end
      default: begin
        prdi_st_d = ST_IDLE;
        hold_cnt_d = 4'h0;
      end
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdi_st_q <= ST_IDLE;
      hold_cnt_q <= 4'h0;
    end else begin
      prdi_st_q <= prdi_st_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // holding from the defect's own cycle keeps rdi up for the full 10 frames
  assign path_rdi_o = (prdi_st_q == ST_HOLD) | path_defect;

  // febe counts latched at each frame start, sent in the following frame
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_febe_q <= 8'h00;
      path_febe_q <= 4'h0;
    end else if (frame_start_i) begin
      line_febe_q <= line_ctrl_q[`SLO_LN_FEBE_AUTO] ? rx_b2_err_i : 8'h00; // R10 R19
      path_febe_q <= path_ctrl_q[`SLO_PT_FEBE_AUTO] ? rx_b3_err_i : 4'h0; // R13 R19
    end
  end

  // per-frame overhead values registered for the framer
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      j0_o <= 8'h00;
      j1_o <= 8'h00;
      k2_o <= 8'h00;
      g1_o <= 8'h00;
      m1_o <= 8'h00;
    end else begin
      j0_o <= sec_byte; // R1
      j1_o <= path_ctrl_q[`SLO_PT_TRACE_EN] ? path_byte : `SLO_ZERO_BYTE; // R11
      // K2 bits 6-8 are the low three bits here, msb-first numbering
      if (line_rdi_o) begin
        k2_o <= {k2_q[7:3], `SLO_LRDI_CODE}; // R8
      end else begin
        k2_o <= k2_q; // R8
      end
      // G1: febe in bits 1-4, auto rdi in bit 5 with bits 6-8 zero, else control bits in bits 5-7 and bit 8 zero
      if (path_ctrl_q[`SLO_PT_RDI_AUTO]) begin
        g1_o <= {path_febe_q, path_rdi_o, 3'b000};
      end else begin
        g1_o <= {path_febe_q, path_ctrl_q[3:1], 1'b0}; // R15
      end
      m1_o <= line_febe_q; // R10
    end
  end

  // overhead byte chosen for the current position before alarm overrides
  always @* begin
    case (byte_sel_i)
      SEL_H1: begin
        if (line_ctrl_q[`SLO_LN_PTR_DIS]) begin
          ov_byte = `SLO_PTR_FORCED; // R4
        end else if (line_ctrl_q[`SLO_LN_SDH_PTR]) begin
          ov_byte = `SLO_H1_SDH; // R3
        end else begin
          ov_byte = `SLO_H1_SONET; // R3
        end
      end
      SEL_H2: begin
        ov_byte = line_ctrl_q[`SLO_LN_PTR_DIS] ? `SLO_PTR_FORCED : `SLO_H2_VAL; // R3 R4
      end
      SEL_B2: begin
        ov_byte = line_ctrl_q[`SLO_LN_B2_DIS] ? `SLO_ZERO_BYTE : b2_calc_i; // R5
      end
      SEL_DL: begin
        ov_byte = line_ctrl_q[`SLO_LN_DL_EN] ? dl_byte_i : `SLO_ZERO_BYTE; // R6
      end
      SEL_K1: begin
        ov_byte = (sts_sel_i == 2'b00) ? k1_i : `SLO_ZERO_BYTE;
      end
      SEL_K2: begin
        ov_byte = (sts_sel_i == 2'b00) ? k2_o : `SLO_ZERO_BYTE; // R17
      end
      SEL_M1: begin
        ov_byte = m1_o;
      end
      SEL_J0: begin
        ov_byte = j0_o;
      end
      SEL_J1: begin
        ov_byte = j1_o;
      end
      SEL_B3: begin
        ov_byte = path_ctrl_q[`SLO_PT_B3_DIS] ? `SLO_ZERO_BYTE : b3_calc_i; // R12
      end
      SEL_G1: begin
        ov_byte = g1_o;
      end
      default: begin
        ov_byte = data_i;
      end
    endcase
  end

  // alarm overrides; line ais wins over path ais, neither touches section overhead
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
    end else if (sec_oh_i) begin
      data_o <= ov_byte;
    end else if (line_ctrl_q[`SLO_LN_AIS]) begin
      data_o <= `SLO_ONES_BYTE; // R7
    end else if (path_ctrl_q[`SLO_PT_AIS] &&
        (path_area_i || byte_sel_i == SEL_H1 || byte_sel_i == SEL_H2 ||
        byte_sel_i == SEL_H3)) begin
      data_o <= `SLO_ONES_BYTE; // R14 R18
    end else begin
      data_o <= ov_byte;
    end
  end
endmodule // slo_tx_overhead

// ### verification/slo_tx_overhead_asserts.sv
// slo_tx_overhead_asserts.sv: port checker for the tx overhead block
// assumes: bound to slo_tx_overhead, one clock, async reset
`timescale 1ns/1ps
module slo_tx_overhead_asserts (
  // clock, reset and register port
  input clk_i,
  input rst_i,
  input [7:0] addr_i,
  input [7:0] wdata_i,
  input wr_i,
  input rd_i,
  input [7:0] rdata_o,
  // frame, defects and datapath
  input frame_start_i,
  input rx_los_i,
  input rx_lof_i,
  input rx_ais_l_i,
  input rx_lop_i,
  input rx_ais_p_i,
  input rx_uneq_p_i,
  input rx_plm_p_i,
  input [3:0] byte_sel_i,
  input [1:0] sts_sel_i,
  input sec_oh_i,
  input path_area_i,
  input [7:0] b2_calc_i,
  input [7:0] b3_calc_i,
  input [7:0] dl_byte_i,
  input [7:0] data_o,
  input [7:0] j1_o,
  input line_rdi_o,
  input path_rdi_o
);
  logic [7:0] ln_q;
  logic [7:0] pt_q;
  // no alarm forcing, so byte values come from the control fields
  wire ok = !ln_q[3] && !pt_q[4] && !sec_oh_i;
  wire [7:0] h1_e = ln_q[6] ? 8'h33 : ln_q[7] ? 8'h6A : 8'h62;
  wire [7:0] h2_e = ln_q[6] ? 8'h33 : 8'h0A;
  wire [7:0] b2_e = ln_q[5] ? 8'h00 : b2_calc_i;
  wire [7:0] dl_e = ln_q[4] ? dl_byte_i : 8'h00;
  wire [7:0] b3_e = pt_q[6] ? 8'h00 : b3_calc_i;
  wire ldef = rx_los_i || rx_lof_i || rx_ais_l_i;
  wire pdef = ldef || rx_lop_i || rx_ais_p_i || rx_uneq_p_i || rx_plm_p_i;
  // shadow of both control registers, since only ports are visible
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) begin
      ln_q <= 8'h03;
      pt_q <= 8'h23;
    end else if (wr_i && addr_i == 8'h0D) begin
      ln_q <= wdata_i;
    end else if (wr_i && addr_i == 8'h0E) begin
      pt_q <= wdata_i;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  AST_H1: assert property (byte_sel_i == 4'h1 && ok |=> data_o == $past(h1_e))
    else $error("h1 byte wrong");
  AST_H2: assert property (byte_sel_i == 4'h2 && ok |=> data_o == $past(h2_e))
    else $error("h2 byte wrong");
  AST_B2: assert property (byte_sel_i == 4'h4 && ok |=> data_o == $past(b2_e))
    else $error("b2 byte wrong");
  AST_DL: assert property (byte_sel_i == 4'h5 && ok |=> data_o == $past(dl_e))
    else $error("data link byte wrong");
  AST_B3: assert property (byte_sel_i == 4'h9 && ok |=> data_o == $past(b3_e))
    else $error("b3 byte wrong");
  AST_LAIS: assert property (ln_q[3] && !sec_oh_i |=> data_o == 8'hFF)
    else $error("line ais byte wrong");
  AST_PAIS: assert property (pt_q[4] && !ln_q[3] && !sec_oh_i
    && (path_area_i || byte_sel_i == 4'h3) |=> data_o == 8'hFF)
    else $error("path ais byte wrong");
  AST_K2: assert property (byte_sel_i == 4'h7 && sts_sel_i == 2'h0 && ok
    && ln_q[2] |=> data_o[2:0] == 3'h6)
    else $error("k2 rdi bits wrong");
  AST_LRDI: assert property (ln_q[1] && ldef |-> line_rdi_o)
    else $error("line rdi missing");
  AST_PRDI: assert property (pt_q[0] && pdef |-> path_rdi_o)
    else $error("path rdi missing");
  AST_J1OFF: assert property (frame_start_i && !pt_q[7] ##1 !pt_q[7] |=> j1_o == 8'h00)
    else $error("j1 not zero");
  cover property (ln_q[3] && !sec_oh_i);
  cover property (path_rdi_o ##1 !path_rdi_o);
  cover property (frame_start_i && pt_q[7]);
endmodule // slo_tx_overhead_asserts

bind slo_tx_overhead slo_tx_overhead_asserts u_chk (.clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .frame_start_i, .rx_los_i, .rx_lof_i, .rx_ais_l_i, .rx_lop_i,
  .rx_ais_p_i, .rx_uneq_p_i, .rx_plm_p_i, .byte_sel_i, .sts_sel_i, .sec_oh_i, .path_area_i,
  .b2_calc_i, .b3_calc_i, .dl_byte_i, .data_o, .j1_o, .line_rdi_o, .path_rdi_o);

// ### verification/slo_far_end.sv
// slo_far_end.sv: far terminal model that reads both trace bytes of each frame
// assumes: frame marker and trace outputs share the transmit clock
`timescale 1ns/1ps
module slo_far_end (
  // clock, reset and frame marker
  input wire clk_i,
  input wire rst_i,
  input wire frm_i,
  // trace bytes as sent
  input wire [7:0] j0_i,
  input wire [7:0] j1_i,
  // last trace bytes received
  output logic [7:0] j0_q_o,
  output logic [7:0] j1_q_o
);
  logic [2:0] dly_q;
  // sample late so a trace byte that lags its marker has settled
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) begin
      dly_q <= '0;
      j0_q_o <= '0;
      j1_q_o <= '0;
    end else begin
      dly_q <= {dly_q[1:0], frm_i};
      if (dly_q[2]) begin
        j0_q_o <= j0_i;
        j1_q_o <= j1_i;
      end
    end
endmodule // slo_far_end

// ### verification/sonet_tx_line_path_overhead_test.sv
// sonet_tx_line_path_overhead_test.sv: self-checking bench for the tx overhead block
// assumes: rtl on the include path, checker and far end model compiled first
`timescale 1ns/1ps
module sonet_tx_line_path_overhead_test;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, frame_start_i = 0, sec_oh_i = 0, path_area_i = 0;
  logic [7:0] addr_i = '0, wdata_i = '0, data_i = '0, b2_calc_i = '0, b3_calc_i = '0;
  logic [7:0] dl_byte_i = '0, k1_i = '0, rx_b2_err_i = '0, q, r, ln, sec_rx, pth_rx;
  logic [7:0] rdata_o, data_o, j0_o, j1_o, k2_o, g1_o, m1_o;
  logic [7:0] sb [64], pb [64];
  logic [6:0] df = '0;
  logic [3:0] byte_sel_i = '0, rx_b3_err_i = '0;
  logic [1:0] sts_sel_i = '0;
  logic line_rdi_o, path_rdi_o;
  integer seed = 32'h8D92, fails = 0, tests_run = 0, i;
  always #20 clk_i = ~clk_i;
  slo_tx_overhead u_slo_tx_overhead (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .frame_start_i, .rx_los_i(df[0]), .rx_lof_i(df[1]), .rx_ais_l_i(df[2]),
    .rx_lop_i(df[3]), .rx_ais_p_i(df[4]), .rx_uneq_p_i(df[5]), .rx_plm_p_i(df[6]),
    .rx_b2_err_i, .rx_b3_err_i, .byte_sel_i, .sts_sel_i, .sec_oh_i, .path_area_i, .data_i,
    .b2_calc_i, .b3_calc_i, .dl_byte_i, .k1_i, .data_o, .j0_o, .j1_o, .k2_o, .g1_o, .m1_o,
    .line_rdi_o, .path_rdi_o);
  slo_far_end u_slo_far_end (.clk_i, .rst_i, .frm_i(frame_start_i), .j0_i(j0_o),
    .j1_i(j1_o), .j0_q_o(sec_rx), .j1_q_o(pth_rx));
  function automatic [7:0] h1x(input [7:0] l);
    h1x = l[6] ? 8'h33 : l[7] ? 8'h6A : 8'h62;
  endfunction
  task automatic chk(input [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input [7:0] a, d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // one byte through the mux; all sources derive from one random value
  task automatic px(input [3:0] s, input pa);
    r = 8'($random(seed));
    @(posedge clk_i);
    byte_sel_i <= s;
    path_area_i <= pa;
    data_i <= r;
    b2_calc_i <= ~r;
    b3_calc_i <= {r[3:0], r[7:4]};
    dl_byte_i <= r ^ 8'h5A;
    k1_i <= r;
    @(posedge clk_i);
    #1 q = data_o;
  endtask
  // frames are spaced so the far end sees each trace byte settle
  task automatic fr(input integer n);
    repeat (n) begin
      @(posedge clk_i);
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    fails++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0D, 8'h03);
    rd(8'h0E, 8'h23);
    rd(8'h3F, 8'h00);
    for (i = 0; i < 16; i++) begin
      q = 8'($random(seed));
      ln = {i[1:0], q[5:4], 4'h3};
      wr(8'h0D, ln);
      px(4'h1, 1'b0);
      chk(q, h1x(ln));
      px(4'h2, 1'b0);
      chk(q, ln[6] ? 8'h33 : 8'h0A);
      px(4'h4, 1'b0);
      chk(q, ln[5] ? 8'h00 : ~r);
      px(4'h5, 1'b0);
      chk(q, ln[4] ? r ^ 8'h5A : 8'h00);
    end
    $display("test line bytes done");
    wr(8'h0D, 8'h0B);
    px(4'h0, 1'b1);
    chk(q, 8'hFF);
    @(posedge clk_i) sec_oh_i <= 1'b1;
    px(4'h0, 1'b0);
    chk(q, r);
    @(posedge clk_i) sec_oh_i <= 1'b0;
    wr(8'h0D, 8'h07);
    wr(8'h11, 8'hA5);
    px(4'h7, 1'b0);
    chk(q, 8'hA6);
    wr(8'h0D, 8'h03);
    rd(8'h11, 8'hA5);
    px(4'h7, 1'b0);
    chk(q, 8'hA5);
    @(posedge clk_i) sts_sel_i <= 2'h1;
    px(4'h7, 1'b0);
    chk(q, 8'h00);
    @(posedge clk_i) sts_sel_i <= 2'h0;
    wr(8'h0E, 8'h63);
    px(4'h9, 1'b1);
    chk(q, 8'h00);
    wr(8'h0E, 8'h33);
    px(4'h3, 1'b0);
    chk(q, 8'hFF);
    px(4'h4, 1'b0);
    chk(q, ~r);
    wr(8'h0E, 8'h23);
    px(4'h9, 1'b1);
    chk(q, {r[3:0], r[7:4]});
    fr(1);
    chk(j1_o, 8'h00);
    wr(8'h0E, 8'h2A);
    rx_b2_err_i <= 8'h07;
    rx_b3_err_i <= 4'h5;
    fr(2);
    chk(g1_o, 8'h5A);
    chk(m1_o, 8'h07);
    wr(8'h0E, 8'h0A);
    wr(8'h0D, 8'h02);
    fr(2);
    chk(g1_o, 8'h0A);
    chk(m1_o, 8'h00);
    $display("test overhead done");
    wr(8'h0D, 8'h03);
    wr(8'h0E, 8'h23);
    for (i = 0; i < 7; i++) begin
      @(posedge clk_i) df <= 7'h01 << i;
      @(posedge clk_i);
      #1 chk({7'h00, path_rdi_o}, 8'h01);
      if (i < 3)
        chk({7'h00, line_rdi_o}, 8'h01);
    end
    @(posedge clk_i) df <= '0;
    fr(9);
    chk({7'h00, path_rdi_o}, 8'h01);
    fr(3);
    chk({7'h00, path_rdi_o}, 8'h00);
    wr(8'h0D, 8'h01);
    df <= 7'h01;
    @(posedge clk_i);
    #1 chk({7'h00, line_rdi_o}, 8'h00);
    @(posedge clk_i) df <= '0;
    $display("test rdi done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0D, 8'h03);
    wr(8'h0E, 8'hA3);
    for (i = 0; i < 64; i++) begin
      {sb[i], pb[i]} = 16'($random(seed));
      wr(8'h68, sb[i]);
      wr(8'h69, pb[i]);
      if (i == 0) rd(8'h68, 8'h01);
    end
    rd(8'h68, 8'h00);
    for (i = 0; i < 66; i++) begin
      fr(1);
      chk(sec_rx, sb[i % 64]);
      chk(pth_rx, pb[i % 64]);
    end
    $display("test trace done");
    results;
  end
endmodule // sonet_tx_line_path_overhead_test
